// >>> mlba_regs.svh
`ifndef MLBA_REGS_SVH
`define MLBA_REGS_SVH

// ----------------------------------------
// master population
// ----------------------------------------
`define MLBA_N_CRY       3
`define MLBA_N_DMA       5

// ----------------------------------------
// slave decode
// ----------------------------------------
`define MLBA_NS          8
`define MLBA_SLV_LSB     28

// ----------------------------------------
// peripheral region and slot size
// ----------------------------------------
`define MLBA_PREG_BASE   32'h40000000
`define MLBA_SLOT_BYTES  32'h00001000
`define MLBA_SLOT_REGS   1024
`define MLBA_PID_W       5

`endif

// >>> mlba_pkg.sv
`include "mlba_regs.svh"

package mlba_pkg;

  // natural priority levels, lower code wins
  typedef enum logic [1:0] {
    MLBA_LVL_CPU  = 2'h0,
    MLBA_LVL_XCVR = 2'h1,
    MLBA_LVL_CRY  = 2'h2,
    MLBA_LVL_DMA  = 2'h3
  } mlba_lvl_t;

  typedef logic [`MLBA_PID_W-1:0] mlba_pid_t;

endpackage

// >>> mlba_arbiter.sv
// How it works
// - each slave has its own arbiter, so masters of different levels aimed at different slaves run in parallel.
// - among masters contending for a free slave the highest-priority one is granted first.
// - a lower master waits, request held, until the owning higher master ends its transaction.
// - while the owner pauses, a queued master gets single beats until the owner asks again.
// - masters of one priority level are never granted together and must not be run together.
// - master index order gives the fixed priority: cpu, transceiver, crypto group, serial group.
// - the crypto_coprocessor_masters and the serial_dma_masters each allow one active member.
// - every peripheral owns one 4096-byte slot of 1024 32-bit registers in the region.
// - the peripheral id is the slot number counted from the region base, 0 up to 31.
`timescale 1ns/100ps
`include "mlba_regs.svh"

module mlba_arbiter #(
  parameter  int N_CRY = `MLBA_N_CRY,
  parameter  int N_DMA = `MLBA_N_DMA,
  parameter  int NS    = `MLBA_NS,
  localparam int NM    = 2 + N_CRY + N_DMA,
  localparam int SW    = (NS > 1) ? $clog2(NS) : 1,
  localparam int MW    = $clog2(NM),
  localparam int PW    = `MLBA_PID_W
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  // master beats
  input  wire logic [NM-1:0]    m_req_i,
  input  wire logic [NM-1:0]    m_last_i,
  input  wire logic [NM*32-1:0] m_addr_i,
  // master grants
  output logic      [NM-1:0]    m_gnt_o,
  // slave ownership
  output logic      [NS-1:0]    s_busy_o,
  output logic      [NS*MW-1:0] s_owner_o,
  // peripheral id decode
  output logic      [NM-1:0]    m_pid_hit_o,
  output logic      [NM*PW-1:0] m_pid_o
);

  localparam logic [31:0] PBASE    = `MLBA_PREG_BASE;
  localparam int          SLOT_LSB = $clog2(`MLBA_SLOT_BYTES);
  localparam int          REG_LSB  = SLOT_LSB - $clog2(`MLBA_SLOT_REGS);
  localparam int          RGN_LSB  = SLOT_LSB + PW;

  function automatic mlba_pkg::mlba_lvl_t lvl_of(input int m);
    if (m == 0) begin
      return mlba_pkg::MLBA_LVL_CPU;
    end else if (m == 1) begin
      return mlba_pkg::MLBA_LVL_XCVR;
    end else if (m < 2 + N_CRY) begin
      return mlba_pkg::MLBA_LVL_CRY;
    end else begin
      return mlba_pkg::MLBA_LVL_DMA;
    end
  endfunction

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  logic [SW-1:0] tgt [NM];
  logic [NM-1:0] elig;
  logic [NM-1:0] open_q;
  logic [NM-1:0] slv_gnt [NS];

  // ----------------------------------------
  // target slave and peripheral id
  // ----------------------------------------
  for (genvar m = 0; m < NM; m++) begin : g_mst
    assign tgt[m] = m_addr_i[m*32+`MLBA_SLV_LSB +: SW];

    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        m_pid_hit_o[m] <= 1'b0;
      end else begin
        m_pid_hit_o[m] <= (m_addr_i[m*32+RGN_LSB +: 32-RGN_LSB] == PBASE[31:RGN_LSB]);
      end
    end

    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        m_pid_o[m*PW +: PW] <= '0;
      end else begin
        m_pid_o[m*PW +: PW] <= m_addr_i[m*32+SLOT_LSB +: PW];
      end
    end

    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        open_q[m] <= 1'b0;
      end else if (m_gnt_o[m]) begin
        open_q[m] <= ~m_last_i[m];
      end
    end
  end

  // ----------------------------------------
  // group exclusion
  // ----------------------------------------
  // one member per level
  always_comb begin
    logic grp_open;
    logic lower_req;
    grp_open  = 1'b0;
    lower_req = 1'b0;
    elig      = '0;
    for (int m = 0; m < NM; m++) begin
      grp_open  = 1'b0;
      lower_req = 1'b0;
      for (int j = 0; j < NM; j++) begin
        if (j != m && lvl_of(j) == lvl_of(m)) begin
          grp_open  = grp_open | open_q[j];
          lower_req = lower_req | ((j < m) & m_req_i[j]);
        end
      end
      if (open_q[m]) begin
        elig[m] = m_req_i[m];
      end else begin
        elig[m] = m_req_i[m] & ~grp_open & ~lower_req;
      end
    end
  end

  // ----------------------------------------
  // per-slave arbiters
  // ----------------------------------------
  // independent paths
  for (genvar s = 0; s < NS; s++) begin : g_slv
    logic [NM-1:0] cand;
    logic [NM-1:0] gnt;
    logic [MW-1:0] gidx;
    logic          own_v_q;
    logic [MW-1:0] own_q;

    always_comb begin
      for (int m = 0; m < NM; m++) begin
        cand[m] = elig[m] & (tgt[m] == SW'(s));
      end
    end

    always_comb begin
      logic found;
      found = 1'b0;
      gnt   = '0;
      gidx  = '0;
      if (own_v_q && cand[own_q]) begin
        gnt[own_q] = 1'b1;
        gidx       = own_q;
      end else begin
        // lowest index wins, also while owner pauses
        for (int m = 0; m < NM; m++) begin
          if (cand[m] && !found) begin
            gnt[m] = 1'b1;
            gidx   = MW'(m);
            found  = 1'b1;
          end
        end
      end
    end

    assign slv_gnt[s] = gnt;

    // ownership moves at beat boundaries only
    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        own_v_q <= 1'b0;
        own_q   <= '0;
      end else if (|gnt) begin
        if (own_v_q && gidx == own_q && m_last_i[gidx]) begin
          own_v_q <= 1'b0;
        end else if (!own_v_q && !m_last_i[gidx]) begin
          own_v_q <= 1'b1;
          own_q   <= gidx;
        end
      end
    end

    assign s_busy_o[s]            = own_v_q;
    assign s_owner_o[s*MW +: MW]  = own_q;

    slave_onehot_a: assert property ($onehot0(gnt))
      else $error("two masters granted one slave");
    slave_serve_a: assert property (|cand |-> |gnt)
      else $error("eligible request left idle");
    free_prio_a: assert property (!own_v_q && |cand |-> gnt == (cand & (~cand + NM'(1))))
      else $error("free slave not given to top priority");
    owner_hold_a: assert property (own_v_q && cand[own_q] |-> gnt[own_q])
      else $error("owner lost slave while requesting");
    pause_lend_a: assert property (own_v_q && !cand[own_q] && |cand
                                   |-> !gnt[own_q] ##1 own_v_q)
      else $error("paused owner not lent out or dropped");
    owner_keep_a: assert property (own_v_q && !(gnt[own_q] && m_last_i[own_q])
                                   |=> own_v_q && own_q == $past(own_q))
      else $error("ownership changed inside transaction");
    owner_free_a: assert property (own_v_q && gnt[own_q] && m_last_i[own_q] |=> !own_v_q)
      else $error("slave not freed after last beat");
    lend_c: cover property (own_v_q && !cand[own_q] && |cand ##1 gnt[own_q]);
    contend_c: cover property (!own_v_q && !$onehot0(cand));
  end

  always_comb begin
    m_gnt_o = '0;
    for (int s = 0; s < NS; s++) begin
      m_gnt_o = m_gnt_o | slv_gnt[s];
    end
  end

  // ----------------------------------------
  // checks across masters
  // ----------------------------------------
  logic [PW-1:0] a0_slot;
  logic          a0_in_rgn;
  assign a0_slot   = m_addr_i[SLOT_LSB +: PW];
  assign a0_in_rgn = (m_addr_i[31:RGN_LSB] == PBASE[31:RGN_LSB]);

  cry_excl_a: assert property ($onehot0(open_q[2 +: N_CRY] | (m_gnt_o[2 +: N_CRY])))
    else $error("two crypto masters active");
  dma_excl_a: assert property ($onehot0(open_q[NM-1 -: N_DMA] | m_gnt_o[NM-1 -: N_DMA]))
    else $error("two serial masters active");
  cpu_first_a: assert property (m_req_i[0] && !(|s_busy_o) |-> m_gnt_o[0])
    else $error("cpu stalled on free fabric");
  pid_dec_a: assert property (a0_in_rgn
                              |=> m_pid_hit_o[0] && m_pid_o[PW-1:0] == $past(a0_slot))
    else $error("peripheral id wrong");
  pid_miss_a: assert property (!a0_in_rgn |=> !m_pid_hit_o[0])
    else $error("address outside region hit");
  pid_top_c: cover property (m_pid_hit_o[0] && m_pid_o[PW-1:0] == '1);
  dma_hand_c: cover property (m_gnt_o[NM-1] ##[1:20] m_gnt_o[NM-2]);

  logic unused_reg_lsb;
  assign unused_reg_lsb = (REG_LSB == 2);

endmodule

// >>> mlba_master_model.sv
`timescale 1ns/100ps

module mlba_master_model #(
  parameter int NM = 10
) (
  // clock
  input  wire logic             clk_sys_i,
  // grants
  input  wire logic [NM-1:0]    m_gnt_i,
  // master beats
  output logic      [NM-1:0]    m_req_o,
  output logic      [NM-1:0]    m_last_o,
  output logic      [NM*32-1:0] m_addr_o
);
  initial begin
    m_req_o  = '0;
    m_last_o = '0;
    m_addr_o = '0;
  end

  task automatic issue(input int m, input logic last, input logic [31:0] addr);
    m_req_o[m]           = 1'b1;
    m_last_o[m]          = last;
    m_addr_o[m*32 +: 32] = addr;
  endtask

  // beat held until granted
  // released lines show inverted junk, not the old beat
  always @(posedge clk_sys_i) begin
    for (int m = 0; m < NM; m++) begin
      if (m_req_o[m] && m_gnt_i[m]) begin
        m_req_o[m]           <= 1'b0;
        m_last_o[m]          <= ~m_last_o[m];
        m_addr_o[m*32 +: 32] <= ~m_addr_o[m*32 +: 32];
      end
    end
  end
endmodule

// >>> test_multilayer_bus_arbiter.sv
`timescale 1ns/100ps

module test_multilayer_bus_arbiter;
  typedef struct packed {logic [9:0] gnt; logic [7:0] busy;} mlba_exp_t;

  logic         clk_sys_i = 1'b0;
  logic         reset_i   = 1'b1;
  logic [9:0]   req;
  logic [9:0]   last;
  logic [9:0]   gnt;
  logic [9:0]   hit;
  logic [319:0] addr;
  logic [7:0]   busy;
  logic [31:0]  owner;
  logic [49:0]  pid;
  int           fails   = 0;
  int           checked = 0;
  int           cycles  = 0;
  mlba_exp_t    q[$];
  logic [59:0]  pq[$];
  logic [3:0]   oq[$];

  always #25 clk_sys_i = ~clk_sys_i;

  mlba_master_model #(.NM(10)) mst (.clk_sys_i(clk_sys_i), .m_gnt_i(gnt), .m_req_o(req),
    .m_last_o(last), .m_addr_o(addr));

  mlba_arbiter DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .m_req_i(req), .m_last_i(last),
    .m_addr_i(addr), .m_gnt_o(gnt), .s_busy_o(busy), .s_owner_o(owner), .m_pid_hit_o(hit),
    .m_pid_o(pid));

  task automatic report(input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic cmp_gnt(input mlba_exp_t e);
    report(64'(e), 64'({gnt, busy}));
  endtask

  task automatic cmp_pid(input logic [59:0] e);
    report(64'(e), 64'({pid, hit}));
  endtask

  // owner of slave 1
  task automatic cmp_own(input logic [3:0] e);
    report(64'(e), 64'(owner[7:4]));
  endtask

  task automatic end_sim;
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic tick;
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic note(input logic [9:0] g, input logic [7:0] b);
    q.push_back({g, b});
    tick();
  endtask

  // -------------------------------------
  // watcher
  // -------------------------------------
  always @(negedge clk_sys_i) begin
    if (q.size() > 0) cmp_gnt(q.pop_front());
    if (pq.size() > 0) cmp_pid(pq.pop_front());
    if (oq.size() > 0) cmp_own(oq.pop_front());
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 200) begin
      fails++;
      end_sim();
    end
  end

  // -------------------------------------
  // stimulus
  // -------------------------------------
  initial begin
    logic [31:0] a;
    logic [59:0] p;
    void'($urandom(85187));
    repeat (12) @(posedge clk_sys_i);
    #1 reset_i = 1'b0;
    tick();
    // all masters on slave 4, random peripheral slots
    p = '0;
    for (int m = 0; m < 10; m++) begin
      a = 32'h40000000 | ($urandom & 32'h0003fffc);
      mst.issue(m, 1'b1, a);
      p[m]             = (a[31:17] == 15'h2000);
      p[10+m*5 +: 5]   = a[16:12];
    end
    for (int m = 0; m < 10; m++) begin
      note(10'h001 << m, 8'h00);
      if (m == 0) pq.push_back(p);
    end
    for (int m = 0; m < 7; m++) begin
      if (m != 4) mst.issue(m, 1'b1, {1'b0, 3'(m), 28'h0000100});
    end
    note(10'h027, 8'h00);
    note(10'h048, 8'h00);
    // pause lends the slave, owner then keeps it to its last beat
    mst.issue(0, 1'b0, 32'h10000000);
    mst.issue(5, 1'b1, 32'h10000040);
    note(10'h001, 8'h00);
    note(10'h020, 8'h02);
    mst.issue(0, 1'b1, 32'h10000004);
    mst.issue(5, 1'b0, 32'h10000044);
    note(10'h001, 8'h02);
    note(10'h020, 8'h00);
    // lower owner keeps the slave, its group stays closed
    mst.issue(0, 1'b1, 32'h10000008);
    mst.issue(5, 1'b1, 32'h10000048);
    mst.issue(6, 1'b1, 32'h60000000);
    oq.push_back(4'h5);
    note(10'h020, 8'h02);
    note(10'h041, 8'h00);
    // reset drops an open owner and its group lock
    mst.issue(2, 1'b0, 32'h20000000);
    note(10'h004, 8'h00);
    reset_i = 1'b1;
    note(10'h000, 8'h04);
    reset_i = 1'b0;
    mst.issue(3, 1'b1, 32'h30000000);
    note(10'h008, 8'h00);
    tick();
    end_sim();
  end
endmodule
